// >>> hw/ird_top.sv
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module ird_top
  import ird_pkg::*;
#(
  parameter int CACHE_ENTRIES = 8,
  parameter bit COHERENT = 1'b1
)
(
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Register bus.
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Upstream write requests.
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [31:0] IN_ADDR,
  input wire logic [31:0] IN_DATA,
  input wire logic [3:0] IN_BE,
  input wire logic [15:0] IN_SRC_ID,
  // Ordinary memory write path.
  output logic MW_VALID,
  input wire logic MW_READY,
  output logic [31:0] MW_ADDR,
  output logic [31:0] MW_DATA,
  output logic [3:0] MW_BE,
  // Interrupt delivery path.
  output logic INT_VALID,
  input wire logic INT_READY,
  output logic [31:0] INT_ADDR,
  output logic [31:0] INT_DATA,
  output logic INT_REMAPPED,
  // Remap table fetch.
  output logic MEM_REQ_VALID,
  input wire logic MEM_REQ_READY,
  output logic [63:0] MEM_REQ_ADDR,
  output logic MEM_REQ_NOSNOOP,
  input wire logic MEM_RSP_VALID,
  input wire logic [127:0] MEM_RSP_DATA,
  input wire logic MEM_RSP_ERR,
  // Fault report.
  output logic FAULT_VALID,
  output logic [7:0] FAULT_REASON,
  output logic [15:0] FAULT_SRC_ID,
  output logic [15:0] FAULT_INDEX
);

  localparam int CW = $clog2(CACHE_ENTRIES);

  generate
    if (CACHE_ENTRIES < 2 || CACHE_ENTRIES > 256 || (1 << CW) != CACHE_ENTRIES)
    begin : g_bad_cache
      $error("CACHE_ENTRIES must be a power of two from 2 to 256.");
    end
  endgenerate

  // ****************************************************************
  // Register bus slave.
  // ****************************************************************
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [31:0] base_lo_ff, nxt_base_lo, base_hi_ff, nxt_base_hi;
  logic [16:0] size_ff, nxt_size;
  logic [31:0] fault_ff, nxt_fault;
  logic [15:0] fault_src_ff, nxt_fault_src;
  logic wr_en, inval_all, inval_one;
  logic [15:0] inval_idx;
  logic rec_fault;
  ird_state_t state_ff, nxt_state;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_ff;
  assign AVS_READDATA = rdata_ff;
  assign wr_en = AVS_WRITE & ack_ff;
  assign inval_all = wr_en && AVS_ADDRESS[4:2] == REG_INVAL[4:2] && AVS_BYTEENABLE[0] &&
                     AVS_WRITEDATA[INVAL_ALL_BIT];
  assign inval_one = wr_en && AVS_ADDRESS[4:2] == REG_INVAL[4:2] && AVS_BYTEENABLE[0] &&
                     AVS_WRITEDATA[INVAL_ONE_BIT];
  assign inval_idx = AVS_WRITEDATA[31:16];

  always_comb
  begin
    logic [31:0] m;
    m = 32'h00000000;
    nxt_ack = (AVS_READ | AVS_WRITE) & ~ack_ff;
    nxt_rdata = rdata_ff;
    nxt_ctrl = ctrl_ff;
    nxt_base_lo = base_lo_ff;
    nxt_base_hi = base_hi_ff;
    nxt_size = size_ff;
    nxt_fault = fault_ff;
    nxt_fault_src = fault_src_ff;
    if (AVS_READ && !ack_ff)
    begin
      unique case (AVS_ADDRESS[4:2])
        REG_CTRL[4:2]: nxt_rdata = {30'h00000000, ctrl_ff};
        REG_TBL_BASE_LO[4:2]: nxt_rdata = base_lo_ff;
        REG_TBL_BASE_HI[4:2]: nxt_rdata = base_hi_ff;
        REG_TBL_SIZE[4:2]: nxt_rdata = {15'h0000, size_ff};
        REG_FAULT[4:2]: nxt_rdata = fault_ff;
        REG_FAULT_SRC[4:2]: nxt_rdata = {16'h0000, fault_src_ff};
        REG_INVAL[4:2]: nxt_rdata = 32'h00000000;
        REG_CAP[4:2]: nxt_rdata = {30'h00000000, state_ff != ST_IDLE, COHERENT};
      endcase
    end
    if (wr_en)
    begin
      unique case (AVS_ADDRESS[4:2])
        REG_CTRL[4:2]:
        begin
          m = be_merge({30'h00000000, ctrl_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);
          nxt_ctrl = m[1:0];
        end
        REG_TBL_BASE_LO[4:2]: nxt_base_lo = be_merge(base_lo_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
        REG_TBL_BASE_HI[4:2]: nxt_base_hi = be_merge(base_hi_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
        REG_TBL_SIZE[4:2]:
        begin
          m = be_merge({15'h0000, size_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);
          nxt_size = (m[16:0] > TBL_SIZE_MAX) ? TBL_SIZE_MAX : m[16:0];
        end
        REG_FAULT[4:2]:
        begin
          if (AVS_BYTEENABLE[0])
          begin
            nxt_fault[1:0] = fault_ff[1:0] & ~AVS_WRITEDATA[1:0];
          end
        end
        default: nxt_fault = nxt_fault;
      endcase
    end
    if (rec_fault)
    begin
      nxt_fault[FAULT_OVF_BIT] = fault_ff[FAULT_PEND_BIT] | nxt_fault[FAULT_OVF_BIT];
      nxt_fault[FAULT_PEND_BIT] = 1'b1;
      nxt_fault[15:8] = FAULT_REASON;
      nxt_fault[31:16] = FAULT_INDEX;
      nxt_fault_src = FAULT_SRC_ID;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      ctrl_ff <= CTRL_RESET;
      base_lo_ff <= 32'h00000000;
      base_hi_ff <= 32'h00000000;
      size_ff <= TBL_SIZE_RESET;
      fault_ff <= 32'h00000000;
      fault_src_ff <= 16'h0000;
    end
    else
    begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      ctrl_ff <= nxt_ctrl;
      base_lo_ff <= nxt_base_lo;
      base_hi_ff <= nxt_base_hi;
      size_ff <= nxt_size;
      fault_ff <= nxt_fault;
      fault_src_ff <= nxt_fault_src;
    end
  end

  // ****************************************************************
  // Remap entry cache.
  // ****************************************************************
  logic [127:0] c_data [CACHE_ENTRIES];
  logic [15-CW:0] c_tag [CACHE_ENTRIES];
  logic [CACHE_ENTRIES-1:0] c_vld_ff, nxt_c_vld;
  logic fill_en, c_hit, inv_pend_ff, nxt_inv_pend;
  logic [15:0] idx_ff, nxt_idx;
  logic [CW-1:0] c_slot;

  assign c_slot = idx_ff[CW-1:0];
  assign c_hit = c_vld_ff[c_slot] && c_tag[c_slot] == idx_ff[15:CW];

  always_comb
  begin
    nxt_c_vld = c_vld_ff;
    if (fill_en)
    begin
      nxt_c_vld[c_slot] = 1'b1;
    end
    if (inval_all)
    begin
      nxt_c_vld = '0;
    end
    else if (inval_one && c_tag[inval_idx[CW-1:0]] == inval_idx[15:CW])
    begin
      nxt_c_vld[inval_idx[CW-1:0]] = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      c_vld_ff <= '0;
    end
    else
    begin
      c_vld_ff <= nxt_c_vld;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (fill_en)
    begin
      c_data[c_slot] <= MEM_RSP_DATA;
      c_tag[c_slot] <= idx_ff[15:CW];
    end
  end

  // ****************************************************************
  // Request decode, checks and output generation.
  // ****************************************************************
  logic [31:0] req_addr_ff, nxt_req_addr, req_data_ff, nxt_req_data;
  logic [3:0] req_be_ff, nxt_req_be;
  logic [15:0] req_src_ff, nxt_req_src;
  logic [127:0] ent_ff, nxt_ent;
  logic [31:0] int_addr_ff, nxt_int_addr, int_data_ff, nxt_int_data;
  logic int_remap_ff, nxt_int_remap;
  logic [63:0] mem_addr_ff, nxt_mem_addr;
  logic [7:0] flt_reason_ff, nxt_flt_reason;
  logic flt_report_ff, nxt_flt_report;
  logic is_int, fmt_remap, subhandle_valid, req_rsvd_bad, idx_over, ent_bad, src_ok;
  logic [15:0] handle, expected_source_id, sq_mask;
  logic [16:0] index_sum;

  assign is_int = req_addr_ff[31:20] == IRQ_ADDR_ID && req_be_ff == DWORD_BE;
  assign fmt_remap = req_addr_ff[ADDR_FMT_BIT];
  assign subhandle_valid = req_addr_ff[ADDR_SHV_BIT];
  // Address bits 1:0 take no part in any decision below.
  assign handle = {req_addr_ff[ADDR_HANDLE_MSB_BIT], req_addr_ff[19:5]};
  assign req_rsvd_bad = subhandle_valid && req_data_ff[31:16] != 16'h0000;
  assign index_sum = subhandle_valid ? {1'b0, handle} + {1'b0, req_data_ff[15:0]}
                         : {1'b0, handle};
  assign idx_over = index_sum >= size_ff;
  assign expected_source_id = ent_ff[ENT_SID_LO +: 16];
  assign ent_bad = (ent_ff & ENT_RSVD_MASK) != '0 || ent_ff[ENT_SVT_LO +: 2] == 2'h3;
  always_comb
  begin
    unique case (ent_ff[ENT_SQ_LO +: 2])
      2'h0: sq_mask = 16'hFFFF;
      2'h1: sq_mask = 16'hFFFB;
      2'h2: sq_mask = 16'hFFF9;
      2'h3: sq_mask = 16'hFFF8;
    endcase
    unique case (ent_ff[ENT_SVT_LO +: 2])
      SVT_FULL: src_ok = (req_src_ff & sq_mask) == (expected_source_id & sq_mask);
      SVT_BUS_RANGE: src_ok = req_src_ff[15:8] >= expected_source_id[15:8] && req_src_ff[15:8] <= expected_source_id[7:0];
      default: src_ok = 1'b1;
    endcase
  end

  assign IN_READY = state_ff == ST_IDLE;
  assign MW_VALID = state_ff == ST_EMIT_MW;
  assign MW_ADDR = req_addr_ff;
  assign MW_DATA = req_data_ff;
  assign MW_BE = req_be_ff;
  assign INT_VALID = state_ff == ST_EMIT_INT;
  assign INT_ADDR = int_addr_ff;
  assign INT_DATA = int_data_ff;
  assign INT_REMAPPED = int_remap_ff;
  assign MEM_REQ_VALID = state_ff == ST_FETCH;
  assign MEM_REQ_ADDR = mem_addr_ff;
  assign MEM_REQ_NOSNOOP = !COHERENT;
  assign FAULT_VALID = state_ff == ST_FAULT && flt_report_ff;
  assign FAULT_REASON = flt_reason_ff;
  assign FAULT_SRC_ID = req_src_ff;
  assign FAULT_INDEX = idx_ff;
  assign rec_fault = FAULT_VALID;
  assign fill_en = state_ff == ST_WAIT && MEM_RSP_VALID && !MEM_RSP_ERR && !inv_pend_ff;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_req_addr = req_addr_ff;
    nxt_req_data = req_data_ff;
    nxt_req_be = req_be_ff;
    nxt_req_src = req_src_ff;
    nxt_idx = idx_ff;
    nxt_ent = ent_ff;
    nxt_int_addr = int_addr_ff;
    nxt_int_data = int_data_ff;
    nxt_int_remap = int_remap_ff;
    nxt_mem_addr = mem_addr_ff;
    nxt_flt_reason = flt_reason_ff;
    nxt_flt_report = flt_report_ff;
    nxt_inv_pend = inv_pend_ff | inval_all | inval_one;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (IN_VALID)
        begin
          nxt_req_addr = IN_ADDR;
          nxt_req_data = IN_DATA;
          nxt_req_be = IN_BE;
          nxt_req_src = IN_SRC_ID;
          nxt_state = ST_CLASSIFY;
        end
      end
      ST_CLASSIFY:
      begin
        nxt_idx = index_sum[15:0];
        nxt_flt_report = 1'b1;
        nxt_int_addr = req_addr_ff;
        nxt_int_data = req_data_ff;
        nxt_int_remap = 1'b0;
        if (!is_int)
        begin
          nxt_state = ST_EMIT_MW;
        end
        else if (!ctrl_ff[CTRL_REMAP_EN_BIT] || !fmt_remap)
        begin
          if (ctrl_ff[CTRL_REMAP_EN_BIT] && !ctrl_ff[CTRL_COMPAT_BIT])
          begin
            nxt_flt_reason = FLT_COMPAT_BLOCK;
            nxt_state = ST_FAULT;
          end
          else
          begin
            nxt_state = ST_EMIT_INT;
          end
        end
        else if (req_rsvd_bad)
        begin
          nxt_flt_reason = FLT_REQ_RSVD;
          nxt_state = ST_FAULT;
        end
        else if (idx_over)
        begin
          nxt_flt_reason = FLT_INDEX_RANGE;
          nxt_state = ST_FAULT;
        end
        else
        begin
          nxt_state = ST_LOOKUP;
        end
      end
      ST_LOOKUP:
      begin
        nxt_mem_addr = {base_hi_ff, base_lo_ff[31:12], 12'h000} + {44'h00000000000, idx_ff, 4'h0};
        nxt_inv_pend = 1'b0;
        if (c_hit)
        begin
          nxt_ent = c_data[c_slot];
          nxt_state = ST_VERIFY;
        end
        else
        begin
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        if (MEM_REQ_READY)
        begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (MEM_RSP_VALID && MEM_RSP_ERR)
        begin
          nxt_flt_reason = FLT_TABLE_ERR;
          nxt_state = ST_FAULT;
        end
        else if (MEM_RSP_VALID)
        begin
          nxt_ent = MEM_RSP_DATA;
          nxt_state = ST_VERIFY;
        end
      end
      ST_VERIFY:
      begin
        nxt_flt_report = !ent_ff[ENT_FPD];
        nxt_state = ST_FAULT;
        if (!ent_ff[ENT_PRESENT])
        begin
          nxt_flt_reason = FLT_NOT_PRESENT;
        end
        else if (ent_bad)
        begin
          nxt_flt_reason = FLT_ENTRY_BAD;
        end
        else if (!src_ok)
        begin
          nxt_flt_reason = FLT_SRC_ID;
        end
        else
        begin
          nxt_int_addr = {IRQ_ADDR_ID, ent_ff[ENT_DEST_LO +: 8], 7'h00, 1'b0,
                          ent_ff[ENT_REDIR], ent_ff[ENT_DEST_MODE], 2'h0};
          nxt_int_data = {16'h0000, ent_ff[ENT_TRIGGER], 4'h0, ent_ff[ENT_DELIV_LO +: 3],
                          ent_ff[ENT_VECTOR_LO +: 8]};
          nxt_int_remap = 1'b1;
          nxt_flt_report = 1'b1;
          nxt_state = ST_EMIT_INT;
        end
      end
      ST_EMIT_INT:
      begin
        if (INT_READY)
        begin
          nxt_state = ST_IDLE;
        end
      end
      ST_EMIT_MW:
      begin
        if (MW_READY)
        begin
          nxt_state = ST_IDLE;
        end
      end
      ST_FAULT: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_ff <= ST_IDLE;
      req_addr_ff <= 32'h00000000;
      req_data_ff <= 32'h00000000;
      req_be_ff <= 4'h0;
      req_src_ff <= 16'h0000;
      idx_ff <= 16'h0000;
      ent_ff <= '0;
      int_addr_ff <= 32'h00000000;
      int_data_ff <= 32'h00000000;
      int_remap_ff <= 1'b0;
      mem_addr_ff <= 64'h0000000000000000;
      flt_reason_ff <= 8'h00;
      flt_report_ff <= 1'b0;
      inv_pend_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      req_addr_ff <= nxt_req_addr;
      req_data_ff <= nxt_req_data;
      req_be_ff <= nxt_req_be;
      req_src_ff <= nxt_req_src;
      idx_ff <= nxt_idx;
      ent_ff <= nxt_ent;
      int_addr_ff <= nxt_int_addr;
      int_data_ff <= nxt_int_data;
      int_remap_ff <= nxt_int_remap;
      mem_addr_ff <= nxt_mem_addr;
      flt_reason_ff <= nxt_flt_reason;
      flt_report_ff <= nxt_flt_report;
      inv_pend_ff <= nxt_inv_pend;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  sequence s_classify;
    state_ff == ST_CLASSIFY && is_int && ctrl_ff[CTRL_REMAP_EN_BIT] && fmt_remap;
  endsequence
  sequence s_fetch_done;
    MEM_REQ_VALID && MEM_REQ_READY ##1 state_ff == ST_WAIT;
  endsequence

  AST_NONINT_TO_MW: assert property (state_ff == ST_CLASSIFY && !is_int |=>
    MW_VALID && MW_ADDR == $past(req_addr_ff) && !INT_VALID) else $error("Bad memory write path.");
  AST_DISABLED_PASS: assert property (state_ff == ST_CLASSIFY && is_int &&
    !ctrl_ff[CTRL_REMAP_EN_BIT] |=> INT_VALID && !INT_REMAPPED) else $error("Disabled not passed.");
  AST_COMPAT_BLOCK: assert property (state_ff == ST_CLASSIFY && is_int && !fmt_remap &&
    ctrl_ff == 2'h1 |=> FAULT_VALID && FAULT_REASON == FLT_COMPAT_BLOCK) else $error("Compat leak.");
  AST_REQ_RSVD: assert property ((s_classify and req_rsvd_bad) |=>
    FAULT_REASON == FLT_REQ_RSVD ##1 state_ff == ST_IDLE) else $error("Reserved not blocked.");
  AST_BOUNDS: assert property ((s_classify and (!req_rsvd_bad && index_sum >= size_ff)) |=>
    FAULT_VALID && FAULT_REASON == FLT_INDEX_RANGE) else $error("Index range not blocked.");
  AST_NOSNOOP: assert property (MEM_REQ_VALID |-> MEM_REQ_NOSNOOP != COHERENT)
    else $error("Snoop attribute wrong.");
  AST_FETCH_WAIT: assert property (s_fetch_done |-> !INT_VALID until state_ff != ST_WAIT)
    else $error("Output during fetch.");
  AST_NOT_PRESENT: assert property (state_ff == ST_VERIFY && !ent_ff[ENT_PRESENT] |=>
    state_ff == ST_FAULT && FAULT_REASON == FLT_NOT_PRESENT) else $error("Absent entry passed.");
  AST_SRC_FAIL: assert property (state_ff == ST_VERIFY && ent_ff[ENT_PRESENT] && !ent_bad &&
    !src_ok |=> !INT_VALID && FAULT_REASON == FLT_SRC_ID) else $error("Source check missed.");
  AST_FPD: assert property (state_ff == ST_VERIFY && ent_ff[ENT_FPD] && nxt_state == ST_FAULT |=>
    !FAULT_VALID ##1 !fault_ff[FAULT_PEND_BIT] || $past(fault_ff[FAULT_PEND_BIT], 2))
    else $error("Suppressed fault reported.");
  AST_BUS_ACK: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("Bus answer late.");

endmodule
`default_nettype wire

// >>> hw/ird_pkg.sv
package ird_pkg;

  // ****************************************************************
  // Register map, byte addresses on the register bus.
  // ****************************************************************
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_TBL_BASE_LO = 5'h04;
  localparam logic [4:0] REG_TBL_BASE_HI = 5'h08;
  localparam logic [4:0] REG_TBL_SIZE = 5'h0C;
  localparam logic [4:0] REG_FAULT = 5'h10;
  localparam logic [4:0] REG_FAULT_SRC = 5'h14;
  localparam logic [4:0] REG_INVAL = 5'h18;
  localparam logic [4:0] REG_CAP = 5'h1C;

  // ****************************************************************
  // Register fields and reset values.
  // ****************************************************************
  localparam int CTRL_REMAP_EN_BIT = 0;
  localparam int CTRL_COMPAT_BIT = 1;
  localparam int FAULT_PEND_BIT = 0;
  localparam int FAULT_OVF_BIT = 1;
  localparam int INVAL_ALL_BIT = 0;
  localparam int INVAL_ONE_BIT = 1;
  localparam int CAP_COHERENT_BIT = 0;
  localparam int CAP_BUSY_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [16:0] TBL_SIZE_RESET = 17'h00000;
  localparam logic [16:0] TBL_SIZE_MAX = 17'h10000;

  // ****************************************************************
  // Interrupt request address and data layout.
  // ****************************************************************
  localparam logic [11:0] IRQ_ADDR_ID = 12'hFEE;
  localparam int ADDR_FMT_BIT = 4;
  localparam int ADDR_SHV_BIT = 3;
  localparam int ADDR_HANDLE_MSB_BIT = 2;
  localparam logic [3:0] DWORD_BE = 4'hF;

  // ****************************************************************
  // Remap entry layout.
  // ****************************************************************
  localparam int ENT_PRESENT = 0;
  localparam int ENT_FPD = 1;
  localparam int ENT_DEST_MODE = 2;
  localparam int ENT_REDIR = 3;
  localparam int ENT_TRIGGER = 4;
  localparam int ENT_DELIV_LO = 5;
  localparam int ENT_VECTOR_LO = 16;
  localparam int ENT_DEST_LO = 32;
  localparam int ENT_SID_LO = 64;
  localparam int ENT_SQ_LO = 80;
  localparam int ENT_SVT_LO = 82;
  localparam logic [127:0] ENT_RSVD_MASK = 128'hFFFFFFFFFFF00000_00000000FF00FF00;
  localparam logic [1:0] SVT_NONE = 2'h0;
  localparam logic [1:0] SVT_FULL = 2'h1;
  localparam logic [1:0] SVT_BUS_RANGE = 2'h2;

  // ****************************************************************
  // Fault reasons.
  // ****************************************************************
  localparam logic [7:0] FLT_REQ_RSVD = 8'h20;
  localparam logic [7:0] FLT_INDEX_RANGE = 8'h21;
  localparam logic [7:0] FLT_NOT_PRESENT = 8'h22;
  localparam logic [7:0] FLT_TABLE_ERR = 8'h23;
  localparam logic [7:0] FLT_ENTRY_BAD = 8'h24;
  localparam logic [7:0] FLT_COMPAT_BLOCK = 8'h25;
  localparam logic [7:0] FLT_SRC_ID = 8'h26;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CLASSIFY, ST_LOOKUP, ST_FETCH, ST_WAIT, ST_VERIFY,
    ST_EMIT_INT, ST_EMIT_MW, ST_FAULT
  } ird_state_t;

endpackage

// >>> testbench/ird_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module ird_mem_model
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Table fetch.
  input wire logic req_valid,
  input wire logic [63:0] req_addr,
  output logic req_ready,
  output logic rsp_valid,
  output logic [127:0] rsp_data,
  output logic rsp_err
);
  // Entry 0 good, 1 absent, 2 checks source id, 3 holds an invalid check type.
  logic [127:0] ent [4] = '{128'h5A0001, 128'h0, 128'h00041234_00000000_00000001,
    128'h000C0000_00000000_00000001};
  logic [127:0] last_ff;
  logic rsp_ff;
  assign req_ready = !rsp_ff;
  assign rsp_valid = rsp_ff;
  assign rsp_err = 1'b0;
  assign rsp_data = rsp_ff ? last_ff : ~last_ff;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rsp_ff <= 1'b0;
      last_ff <= '0;
    end
    else
    begin
      rsp_ff <= req_valid && !rsp_ff;
      if (req_valid && !rsp_ff)
        last_ff <= ent[req_addr[5:4]];
    end
  end
endmodule
`default_nettype wire

// >>> testbench/ird_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ird_top_tb;
  import ird_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, iv = 1'b0;
  logic [4:0] aa = 5'h00;
  logic [31:0] wd = 32'h0, ia = 32'h0, id = 32'h0, avr, rdat, md, xd;
  logic wt, irdy, mv, xv, xr, qv, qr, qn, sv, se, fv;
  logic [63:0] qa;
  logic [127:0] sd;
  logic [7:0] fr;
  logic [15:0] v;
  logic [3:0] k;
  logic [3:0] ib = 4'hF;
  logic [15:0] sr = 16'h0001;
  int error_cnt = 0, check_count = 0, i, n;
  logic [31:0] ta [13] = '{32'h10000000, 32'hFEE00010, 32'hFEE00000, 32'hFEE00018,
    32'hFEE00014, 32'hFEE00013, 32'hFEE00018, 32'hFEE00050, 32'hFEE00038, 32'hFEE00070,
    32'hFEE00004, 32'hFEE00050, 32'hFEE00010};
  logic [31:0] td [13] = '{32'hCAFE, 32'h77, 32'h0, 32'h10000, 32'h0, 32'h0, 32'h1, 32'h0,
    32'h3, 32'h0, 32'h55, 32'h0, 32'h77};
  logic [19:0] te [13] = '{20'h1CAFE, 20'h20077,
    20'h40025, 20'h40020, 20'h40021,
    20'h3005A, 20'h40022, 20'h40026,
    20'h40021, 20'h40024, 20'h20055,
    20'h30000, 20'h10077};
  always #50 clk = ~clk;
  ird_top #(.CACHE_ENTRIES(8), .COHERENT(1'b0)) DUT (
    .CLK_SYS(clk), .RESETN(rstn), .AVS_ADDRESS(aa), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avr), .AVS_WAITREQUEST(wt),
    .IN_VALID(iv), .IN_READY(irdy), .IN_ADDR(ia), .IN_DATA(id), .IN_BE(ib),
    .IN_SRC_ID(sr),
    .MW_VALID(mv), .MW_READY(1'b1), .MW_ADDR(), .MW_DATA(md), .MW_BE(),
    .INT_VALID(xv), .INT_READY(1'b1), .INT_ADDR(), .INT_DATA(xd), .INT_REMAPPED(xr),
    .MEM_REQ_VALID(qv), .MEM_REQ_READY(qr), .MEM_REQ_ADDR(qa), .MEM_REQ_NOSNOOP(qn),
    .MEM_RSP_VALID(sv), .MEM_RSP_DATA(sd), .MEM_RSP_ERR(se), .FAULT_VALID(fv),
    .FAULT_REASON(fr), .FAULT_SRC_ID(), .FAULT_INDEX());
  ird_mem_model u_mem (.clk(clk), .resetn(rstn), .req_valid(qv), .req_addr(qa),
    .req_ready(qr), .rsp_valid(sv), .rsp_data(sd), .rsp_err(se));
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo();
    if (n >= 50)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    aa <= a;
    wd <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wt && n < 50);
    tmo();
    rdat = avr;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic req(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    iv <= 1'b1;
    ia <= a;
    id <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!irdy && n < 50);
    tmo();
    iv <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!(mv || xv || fv) && n < 50);
    tmo();
    k = mv ? 4'h1 : (xv ? (xr ? 4'h3 : 4'h2) : 4'h4);
    v = mv ? md[15:0] : (xv ? xd[15:0] : {8'h00, fr});
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    chk({19'h0, qn}, 20'h1);
    for (i = 0; i < 13; i++)
    begin
      if (i == 11)
        sr <= 16'h1234;
      if (i == 12)
        ib <= 4'h7;
      if (i == 2)
      begin
        bus(1'b1, REG_CTRL, 32'h1);
        bus(1'b1, REG_TBL_SIZE, 32'h4);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(rdat[19:0], 20'h1);
      end
      if (i == 10)
        bus(1'b1, REG_CTRL, 32'h3);
      req(ta[i], td[i]);
      chk({k, v}, te[i]);
    end
    bus(1'b0, REG_FAULT, 32'h0);
    chk({4'h0, rdat[31:16]}, 20'h00003);
    chk({4'h0, rdat[15:0]}, 20'h02403);
    bus(1'b0, REG_FAULT_SRC, 32'h0);
    chk(rdat[19:0], 20'h00001);
    bus(1'b1, REG_FAULT, 32'h3);
    bus(1'b0, REG_FAULT, 32'h0);
    chk({4'h0, rdat[15:0]}, 20'h02400);
    wrap_up();
  end
endmodule
`default_nettype wire
